/* File: core/dac_pacing_defs.svh */
// constants for the analog output pacing sequencer
`ifndef DAC_PACING_DEFS_SVH
`define DAC_PACING_DEFS_SVH
`define PACE_SRC_OWN       2'h0
`define PACE_SRC_AI        2'h1
`define PACE_SRC_EXT       2'h2
`define RANGE_CODE_5V      2'h3
`define RANGE_CODE_10V     2'h2
`define FMT_TWOS12         2'h0
`define FMT_TWOS16         2'h1
`define FMT_SPLIT12        2'h2
`define CODE12_MIN         16'hf800
`define CODE12_MAX         16'h07ff
`define SPLIT_OFFSET       16'h0800
`define CLK_HZ             100000000
`define MAX_RATE_HZ        500000
`define MIN_PERIOD_CYC     (`CLK_HZ / `MAX_RATE_HZ)
`define TIMER_INIT         16'hffff
`define DAC_ZERO           16'h0000
`endif

/* File: core/dac_pacing_pkg.sv */
// types for the analog output pacing sequencer
package dac_pacing_pkg;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ARMED = 2'b01,
        ST_RUN   = 2'b10,
        ST_HALT  = 2'b11
    } seq_state_t;
endpackage

/* File: core/sample_fifo.sv */
// sample fifo with recycle replay and read pointer restart
`timescale 1ns/1ns
module sample_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             flush,
    input  wire logic             recycle,
    input  wire logic             rewind,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("sample_fifo depth must be a power of two");
        end
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_reg;
    logic [AW:0]      rd_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;
    logic             wrap;
    // recycle keeps the loaded buffer, so it is never freed
    assign in_ready  = (wr_reg != (AW+1)'(DEPTH)) && !(recycle && rd_reg != '0);
    assign out_valid = recycle ? (wr_reg != '0) : (count_reg != '0);
    assign out_data  = mem[rd_reg[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign wrap      = recycle && (rd_reg + 1'b1 == wr_reg);
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_reg[AW-1:0]] <= in_data;
        end
    end
    // write pointer counts words since flush, or since the fifo last drained outside recycle
    always_ff @(posedge core_clk) begin
        if (rst || flush) begin
            wr_reg <= '0;
        end else if (push) begin
            wr_reg <= wr_reg + 1'b1;
        end else if (!recycle && count_reg == '0 && wr_reg == rd_reg && wr_reg != '0) begin
            wr_reg <= '0;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst || flush) begin
            rd_reg <= '0;
        // RULE5 - rewind to first
        end else if (rewind && recycle) begin
            rd_reg <= '0;
        // RULE18 - wrap without underflow
        end else if (pop && wrap) begin
            rd_reg <= '0;
        end else if (pop) begin
            rd_reg <= rd_reg + 1'b1;
        end else if (!recycle && count_reg == '0) begin
            rd_reg <= '0;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst || flush) begin
            count_reg <= '0;
        end else if (!recycle) begin
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

/* File: core/dac_output_pacing_fifo.sv */
// analog output sequencer: fifo, pacing, triggers, ranges, underflow stop
// Overview of operation
// RULE1 - ai pacing mode clocks outputs with input pulses once input sampling starts
// RULE2 - external pacer clock taken on rising or falling edge by configuration
// RULE3 - hardware start trigger is a configurable edge on trigger input
// RULE4 - digital start: masked inputs compared to pattern, match or mismatch fires
// RULE5 - recycle with simultaneous start: each trigger rewinds fifo read pointer; only hardware trigger edges in run rewind it here
// RULE6 - 12-bit channels take -2048..+2047, each with own 5 V/10 V range
// RULE7 - range code -1 is 5 V, -2 is 10 V; bipolar only
// RULE8 - 16-bit variant takes -32768..+32767 at fixed 10 V
// RULE9 - split binary variant maps 0 most negative, 4095 most positive
// RULE10 - own output timer paces conversions; host fills fifo by any transfer
// RULE11 - data path sustains conversions up to 500 kHz
// RULE12 - underflow in dma or interrupt mode flags data lost and halts
// RULE13 - without output timer host times updates from input timer or interrupt
// RULE14 - stop trigger counts a programmed nonzero number of samples after start
// RULE15 - host programs digital stop identical to digital start; no digital stop here, a run ends on stop_task, the sample count or underflow
// RULE16 - sample fifo permits gap-free streaming and recycle replay
// RULE17 - after initialization both channels hold code zero
// RULE18 - recycle wraps read pointer to first sample without underflow
// RULE19 - after underflow sequencer stays stopped until cleared and restarted
`timescale 1ns/1ns
`include "dac_pacing_defs.svh"
module dac_output_pacing_fifo #(
    parameter int DATA_W     = 16,
    parameter int FIFO_DEPTH = 16,
    parameter int CHANNELS   = 2,
    parameter int DIN_W      = 4
) (
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    input  wire logic [DATA_W-1:0]       sample_data,
    input  wire logic                    sample_valid,
    output logic                         sample_ready,
    input  wire logic                    start_task,
    input  wire logic                    stop_task,
    input  wire logic                    clear_lost,
    input  wire logic                    recycle_mode,
    input  wire logic                    simultaneous,
    input  wire logic                    transfer_monitored,
    input  wire logic [1:0]              pace_source,
    input  wire logic [15:0]             pace_period,
    input  wire logic                    ai_pace_pulse,
    input  wire logic                    ai_sampling,
    input  wire logic                    ext_pacer_clock_in,
    input  wire logic                    ext_clock_falling,
    input  wire logic                    ext_trigger_in,
    input  wire logic                    trigger_falling,
    input  wire logic                    hw_trigger_en,
    input  wire logic                    digital_start_en,
    input  wire logic [DIN_W-1:0]        din,
    input  wire logic [DIN_W-1:0]        start_mask,
    input  wire logic [DIN_W-1:0]        start_pattern,
    input  wire logic                    start_on_mismatch,
    input  wire logic                    stop_count_en,
    input  wire logic [15:0]             stop_count,
    input  wire logic [1:0]              code_format,
    input  wire logic [2*CHANNELS-1:0]   range_select_code,
    output logic [CHANNELS*DATA_W-1:0]   dac_code,
    output logic [CHANNELS-1:0]          dac_range_10v,
    output logic [CHANNELS-1:0]          dac_update,
    output logic                         running,
    output logic                         data_lost_event,
    output logic                         data_lost
);
    initial begin
        if (DATA_W != 16 || CHANNELS < 1 || CHANNELS > 4 || DIN_W < 1) begin
            $error("dac_output_pacing_fifo parameters unsupported");
        end
    end

    function automatic logic range_is_10v(input logic [1:0] code);
        // RULE7 - bipolar codes only
        range_is_10v = (code == `RANGE_CODE_10V);
    endfunction

    function automatic logic [15:0] format_code(input logic [15:0] raw, input logic [1:0] fmt);
        logic signed [15:0] s;
        s = raw;
        case (fmt)
            // RULE8 - full 16-bit twos complement
            `FMT_TWOS16:  format_code = raw;
            // RULE9 - split binary 0..4095
            `FMT_SPLIT12: format_code = {4'h0, raw[11:0]};
            // RULE6 - clamp to 12-bit range
            default: begin
                if (s < $signed(`CODE12_MIN)) begin
                    format_code = `CODE12_MIN;
                end else if (s > $signed(`CODE12_MAX)) begin
                    format_code = `CODE12_MAX;
                end else begin
                    format_code = raw;
                end
            end
        endcase
    endfunction

    dac_pacing_pkg::seq_state_t state_reg;
    logic [15:0]      timer_reg;
    logic [15:0]      stop_cnt_reg;
    logic [1:0]       chan_reg;
    logic             xclk_prev_reg;
    logic             trig_prev_reg;
    logic             match_prev_reg;
    logic             ai_started_reg;
    logic             ext_edge;
    logic             trig_edge;
    logic             dig_match;
    logic             dig_fire;
    logic             start_event;
    logic             own_tick;
    logic             pace_tick;
    logic             rewind;
    logic [DATA_W-1:0] fifo_data;
    logic             fifo_valid;
    logic             fifo_pop;
    logic             underflow;
    logic             flush;
    logic [15:0]      period_eff;

    // RULE2 - selectable pacer edge
    assign ext_edge = ext_clock_falling ? (xclk_prev_reg && !ext_pacer_clock_in)
                                        : (!xclk_prev_reg && ext_pacer_clock_in);
    // RULE3 - selectable trigger edge
    assign trig_edge = trigger_falling ? (trig_prev_reg && !ext_trigger_in)
                                       : (!trig_prev_reg && ext_trigger_in);
    // RULE4 - mask, pattern, match sense
    assign dig_match   = ((din & start_mask) == start_pattern) ^ start_on_mismatch;
    assign dig_fire    = digital_start_en && dig_match && !match_prev_reg;
    assign start_event = (hw_trigger_en && trig_edge) || dig_fire
                         || (!hw_trigger_en && !digital_start_en);
    // periods under the 500 kHz limit are stretched
    assign period_eff = (pace_period < 16'(`MIN_PERIOD_CYC)) ? 16'(`MIN_PERIOD_CYC)
                                                             : pace_period;
    assign own_tick = (timer_reg == 16'h0001);

    always_comb begin
        case (pace_source)
            // RULE10 - own output timer
            `PACE_SRC_OWN: pace_tick = own_tick;
            // RULE1 - shared input pulse
            `PACE_SRC_AI:  pace_tick = ai_pace_pulse && ai_started_reg;
            `PACE_SRC_EXT: pace_tick = ext_edge;
            default:       pace_tick = 1'b0;
        endcase
    end

    assign fifo_pop  = (state_reg == dac_pacing_pkg::ST_RUN) && pace_tick && fifo_valid;
    // RULE12 - underflow when monitored
    assign underflow = (state_reg == dac_pacing_pkg::ST_RUN) && pace_tick && !fifo_valid
                       && transfer_monitored && !recycle_mode;
    // RULE5 - trigger restarts replay
    assign rewind = recycle_mode && simultaneous && hw_trigger_en && trig_edge
                    && (state_reg == dac_pacing_pkg::ST_RUN);
    assign flush  = stop_task && (state_reg == dac_pacing_pkg::ST_IDLE);
    assign running = (state_reg == dac_pacing_pkg::ST_RUN);

    // RULE16 - sample fifo in path
    sample_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .flush     (flush),
        .recycle   (recycle_mode),
        .rewind    (rewind),
        .in_data   (sample_data),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    always_ff @(posedge core_clk) begin
        if (rst) begin
            xclk_prev_reg  <= 1'b0;
            trig_prev_reg  <= 1'b0;
            match_prev_reg <= 1'b0;
        end else begin
            xclk_prev_reg  <= ext_pacer_clock_in;
            trig_prev_reg  <= ext_trigger_in;
            match_prev_reg <= dig_match;
        end
    end

    // RULE1 - wait for input start
    always_ff @(posedge core_clk) begin
        if (rst || state_reg != dac_pacing_pkg::ST_RUN) begin
            ai_started_reg <= 1'b0;
        end else if (ai_sampling) begin
            ai_started_reg <= 1'b1;
        end
    end

    // RULE11 - reload paces up to max rate
    always_ff @(posedge core_clk) begin
        if (rst) begin
            timer_reg <= `TIMER_INIT;
        end else if (state_reg != dac_pacing_pkg::ST_RUN || own_tick) begin
            timer_reg <= period_eff;
        end else begin
            timer_reg <= timer_reg - 16'h0001;
        end
    end

    // RULE19 - halt until cleared
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= dac_pacing_pkg::ST_IDLE;
        end else begin
            case (state_reg)
                dac_pacing_pkg::ST_IDLE:
                    if (start_task) begin
                        state_reg <= dac_pacing_pkg::ST_ARMED;
                    end
                dac_pacing_pkg::ST_ARMED:
                    if (stop_task) begin
                        state_reg <= dac_pacing_pkg::ST_IDLE;
                    end else if (start_event) begin
                        state_reg <= dac_pacing_pkg::ST_RUN;
                    end
                dac_pacing_pkg::ST_RUN:
                    if (underflow) begin
                        state_reg <= dac_pacing_pkg::ST_HALT;
                    // RULE14 - sample count stop
                    end else if (stop_task || (stop_count_en && fifo_pop
                                 && stop_cnt_reg == 16'h0001)) begin
                        state_reg <= dac_pacing_pkg::ST_IDLE;
                    end
                dac_pacing_pkg::ST_HALT:
                    if (clear_lost) begin
                        state_reg <= dac_pacing_pkg::ST_IDLE;
                    end
                default: state_reg <= dac_pacing_pkg::ST_IDLE;
            endcase
        end
    end

    // RULE14 - count after start
    always_ff @(posedge core_clk) begin
        if (rst || state_reg != dac_pacing_pkg::ST_RUN) begin
            stop_cnt_reg <= (stop_count == 16'h0000) ? 16'h0001 : stop_count;
        end else if (fifo_pop) begin
            stop_cnt_reg <= stop_cnt_reg - 16'h0001;
        end
    end

    // RULE12 - data lost flag
    always_ff @(posedge core_clk) begin
        if (rst) begin
            data_lost <= 1'b0;
        end else if (underflow) begin
            data_lost <= 1'b1;
        end else if (clear_lost) begin
            data_lost <= 1'b0;
        end
        if (rst) begin
            data_lost_event <= 1'b0;
        end else begin
            data_lost_event <= underflow;
        end
    end

    // round robin, so each channel gets a share of the rate
    always_ff @(posedge core_clk) begin
        if (rst || state_reg == dac_pacing_pkg::ST_IDLE) begin
            chan_reg <= 2'h0;
        end else if (fifo_pop) begin
            chan_reg <= (chan_reg == 2'(CHANNELS-1)) ? 2'h0 : chan_reg + 2'h1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_ch
            // RULE17 - zero at reset
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    dac_code[g*DATA_W +: DATA_W] <= `DAC_ZERO;
                    dac_update[g]                <= 1'b0;
                end else begin
                    dac_update[g] <= fifo_pop && chan_reg == 2'(g);
                    if (fifo_pop && chan_reg == 2'(g)) begin
                        dac_code[g*DATA_W +: DATA_W] <= format_code(fifo_data, code_format);
                    end
                end
            end
            // RULE6 - per-channel range
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    dac_range_10v[g] <= 1'b1;
                end else begin
                    dac_range_10v[g] <= (code_format != `FMT_TWOS12)
                                        || range_is_10v(range_select_code[2*g +: 2]);
                end
            end
        end
    endgenerate
endmodule

/* File: testbench/dac_pacing_props.sv */
// checker on the sequencer ports
`timescale 1ns/1ns
`include "dac_pacing_defs.svh"
module dac_pacing_props #(
    parameter int DATA_W   = 16,
    parameter int CHANNELS = 2
) (
    input wire logic                       core_clk,
    input wire logic                       rst,
    input wire logic                       clear_lost,
    input wire logic                       recycle_mode,
    input wire logic                       transfer_monitored,
    input wire logic                       sample_ready,
    input wire logic [1:0]                 code_format,
    input wire logic [2*CHANNELS-1:0]      range_select_code,
    input wire logic [CHANNELS*DATA_W-1:0] dac_code,
    input wire logic [CHANNELS-1:0]        dac_range_10v,
    input wire logic [CHANNELS-1:0]        dac_update,
    input wire logic                       running,
    input wire logic                       data_lost_event,
    input wire logic                       data_lost
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    reset_zero_a: assert property (disable iff (1'b0) rst |=>
        dac_code == '0 && dac_update == '0 && !running && !data_lost && &dac_range_10v)
        else $error("outputs not cleared by reset");
    one_update_a: assert property ($onehot0(dac_update))
        else $error("two channels updated at once");
    update_run_a: assert property (|dac_update |-> $past(running))
        else $error("update outside run");
    span_12_a: assert property (
        dac_update[0] && code_format == `FMT_TWOS12 |-> dac_code[15:11] inside {5'h00, 5'h1f})
        else $error("12-bit code out of span");
    range_pick_a: assert property (
        dac_update[0] && code_format == `FMT_TWOS12
        |-> dac_range_10v[0] == (range_select_code[1:0] == `RANGE_CODE_10V))
        else $error("range select not followed");
    fixed_10v_a: assert property (
        |dac_update && code_format != `FMT_TWOS12 |-> &dac_range_10v)
        else $error("range not fixed at 10 V");
    split_span_a: assert property (
        dac_update[0] && code_format == `FMT_SPLIT12 |-> dac_code[15:12] == 4'h0)
        else $error("split code above 4095");
    lost_cause_a: assert property (
        $rose(data_lost) |-> $past(transfer_monitored) && !$past(recycle_mode) && !running)
        else $error("unexpected data lost");
    halt_held_a: assert property (
        data_lost && !clear_lost |=> data_lost && !running && !data_lost_event)
        else $error("halt left without clear");
    cover property (data_lost_event);
    cover property (!sample_ready);
    cover property (dac_update[1] && code_format == `FMT_SPLIT12);
endmodule

/* File: testbench/host_feeder.sv */
// host model feeding the sample fifo
`timescale 1ns/1ns
module host_feeder (
    input  wire logic   core_clk,
    input  wire logic   rst,
    input  wire logic   stall,
    output logic [15:0] sample_data,
    output logic        sample_valid,
    input  wire logic   sample_ready
);
    logic [15:0] pend[$];
    initial sample_valid = 1'b0;
    initial sample_data = 16'h0000;
    always @(posedge core_clk) begin
        if (rst) begin
            sample_valid <= 1'b0;
        end else if (!sample_valid || sample_ready) begin
            if (sample_valid) begin
                void'(pend.pop_front());
            end
            if (pend.size() != 0 && !stall) begin
                sample_valid <= 1'b1;
                sample_data <= pend[0];
            end else begin
                // idle data toggles so stale words stand out
                sample_valid <= 1'b0;
                sample_data <= ~sample_data;
            end
        end
    end
endmodule

/* File: testbench/testbench.sv */
// bench for the output sequencer
`timescale 1ns/1ns
`include "dac_pacing_defs.svh"
module testbench;
    typedef struct packed {logic ch; logic [15:0] code; logic r10;} note_t;
    logic        core_clk = 1'b0, rst = 1'b1, start_task = 1'b0, stop_task = 1'b0;
    logic        clear_lost = 1'b0, recycle_mode = 1'b0, simultaneous = 1'b0;
    logic        transfer_monitored = 1'b0, ai_pace_pulse = 1'b0, ai_sampling = 1'b0;
    logic        ext_pacer_clock_in = 1'b0, ext_clock_falling = 1'b0, ext_trigger_in = 1'b0;
    logic        trigger_falling = 1'b1, hw_trigger_en = 1'b0, digital_start_en = 1'b0;
    logic        start_on_mismatch = 1'b0, stop_count_en = 1'b0, stall = 1'b0;
    logic        sample_valid, sample_ready, running, data_lost_event, data_lost;
    logic [1:0]  pace_source = `PACE_SRC_OWN, code_format = `FMT_TWOS12;
    logic [1:0]  dac_range_10v, dac_update;
    logic [3:0]  din = 4'h0, start_mask = 4'h3, start_pattern = 4'h2;
    logic [3:0]  range_select_code = {`RANGE_CODE_10V, `RANGE_CODE_5V};
    logic [15:0] pace_period = 16'h00c8, stop_count = 16'h0002, sample_data;
    logic [15:0] rnd = 16'he6cc, srnd = 16'he6cc;
    logic [31:0] dac_code;
    note_t       notes[$];
    int          miscompares = 0, samples_checked = 0, updates_seen = 0;
    dac_output_pacing_fifo dut_u (.core_clk, .rst, .sample_data, .sample_valid, .sample_ready,
        .start_task, .stop_task, .clear_lost, .recycle_mode, .simultaneous, .transfer_monitored,
        .pace_source, .pace_period, .ai_pace_pulse, .ai_sampling, .ext_pacer_clock_in,
        .ext_clock_falling, .ext_trigger_in, .trigger_falling, .hw_trigger_en, .digital_start_en,
        .din, .start_mask, .start_pattern, .start_on_mismatch, .stop_count_en, .stop_count,
        .code_format, .range_select_code, .dac_code, .dac_range_10v, .dac_update, .running,
        .data_lost_event, .data_lost);
    host_feeder feeder_u (.core_clk, .rst, .stall, .sample_data, .sample_valid, .sample_ready);
    always #5 core_clk = ~core_clk;
    function automatic logic [15:0] next_rnd(input logic [15:0] x);
        x = x ^ (x << 7);
        x = x ^ (x >> 9);
        return x ^ (x << 8);
    endfunction
    always @(posedge core_clk) begin
        srnd <= next_rnd(srnd);
        stall <= srnd[0];
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input logic ok, input string what);
        samples_checked++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask
    task automatic timeout(input logic ok);
        check(ok, "wait ran out");
        if (ok !== 1'b1) final_report();
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic go(input logic s);
        @(posedge core_clk);
        start_task <= s;
        stop_task <= ~s;
        @(posedge core_clk);
        start_task <= 1'b0;
        stop_task <= 1'b0;
    endtask
    task automatic wait_updates(input int n);
        int target = updates_seen + n;
        for (int i = 0; i < n * 300 + 50 && updates_seen < target; i++) cyc(1);
        timeout(updates_seen >= target);
    endtask
    task automatic wait_flag(ref logic f, input int n);
        for (int i = 0; i < n && f !== 1'b1; i++) cyc(1);
        timeout(f === 1'b1);
    endtask
    task automatic note(input logic [15:0] w, input logic ch);
        note_t n;
        n = {ch, w, (code_format != `FMT_TWOS12) | ch};
        if (code_format == `FMT_SPLIT12) n.code = {4'h0, w[11:0]};
        if (code_format == `FMT_TWOS12 && $signed(w) > $signed(`CODE12_MAX)) n.code = `CODE12_MAX;
        if (code_format == `FMT_TWOS12 && $signed(w) < $signed(`CODE12_MIN)) n.code = `CODE12_MIN;
        notes.push_back(n);
    endtask
    task automatic send(input logic [15:0] w, input logic ch, input logic expect_out);
        feeder_u.pend.push_back(w);
        if (expect_out) note(w, ch);
    endtask
    always @(posedge core_clk) begin
        if (!rst && dac_update !== 2'b00) begin
            updates_seen++;
            if (notes.size() == 0) begin
                check(1'b0, "unexpected update");
            end else begin
                check(dac_update[notes[0].ch] === 1'b1 && dac_code[notes[0].ch*16 +: 16] ===
                    notes[0].code && dac_range_10v[notes[0].ch] === notes[0].r10, "dac word");
                void'(notes.pop_front());
            end
        end
    end
    initial begin
        cyc(6);
        rst <= 1'b0;
        cyc(1);
        check(dac_code === 32'h0 && running === 1'b0 && sample_ready === 1'b1, "reset");
        for (int i = 0; i < 17; i++) begin
            rnd = next_rnd(rnd);
            send(i == 0 ? 16'h7fff : (i == 1 ? 16'h8000 : {{4{rnd[11]}}, rnd[11:0]}), i[0], 1);
        end
        cyc(100);
        check(sample_ready === 1'b0, "fifo full");
        go(1);
        wait_updates(17);
        go(0);
        $display("test stream done");
        transfer_monitored <= 1'b1;
        send(16'h0123, 0, 1);
        cyc(20);
        go(1);
        wait_flag(data_lost_event, 700);
        go(1);
        cyc(300);
        check(data_lost === 1'b1 && running === 1'b0, "halt");
        clear_lost <= 1'b1;
        cyc(1);
        clear_lost <= 1'b0;
        cyc(2);
        check(data_lost === 1'b0, "clear lost");
        $display("test underflow done");
        stop_count_en <= 1'b1;
        for (int f = 1; f < 3; f++) begin
            code_format <= f[1:0];
            cyc(1);
            for (int i = 0; i < 3; i++) begin
                rnd = next_rnd(rnd);
                send(rnd, i[0], i < 2);
            end
            cyc(20);
            go(1);
            wait_updates(2);
            cyc(450);
            check(running === 1'b0 && data_lost === 1'b0, "stop count");
            go(0);
        end
        stop_count_en <= 1'b0;
        code_format <= `FMT_TWOS12;
        transfer_monitored <= 1'b0;
        cyc(1);
        $display("test formats done");
        for (int m = 0; m < 3; m++) begin
            pace_source <= (m == 2) ? `PACE_SRC_AI : `PACE_SRC_EXT;
            ext_clock_falling <= m[0];
            ext_pacer_clock_in <= ~m[0];
            send(16'h0345, 0, 1);
            cyc(20);
            go(1);
            cyc(4);
            ext_pacer_clock_in <= m[0];
            ai_pace_pulse <= (m == 2);
            cyc(1);
            ai_pace_pulse <= 1'b0;
            cyc(6);
            check(notes.size() === 1, "early tick");
            ai_sampling <= (m == 2);
            cyc(3);
            ext_pacer_clock_in <= ~m[0];
            ai_pace_pulse <= (m == 2);
            cyc(1);
            ai_pace_pulse <= 1'b0;
            wait_updates(1);
            go(0);
            ai_sampling <= 1'b0;
        end
        pace_source <= 2'h3;
        $display("test pacing done");
        for (int m = 0; m < 3; m++) begin
            hw_trigger_en <= (m == 0);
            digital_start_en <= (m != 0);
            start_on_mismatch <= (m == 2);
            din <= (m == 2) ? 4'h6 : 4'h1;
            cyc(3);
            go(1);
            cyc(4);
            ext_trigger_in <= 1'b1;
            cyc(5);
            check(running === 1'b0, "early start");
            ext_trigger_in <= 1'b0;
            din <= (m == 2) ? 4'h1 : 4'h6;
            wait_flag(running, 10);
            go(0);
        end
        digital_start_en <= 1'b0;
        hw_trigger_en <= 1'b1;
        pace_source <= `PACE_SRC_OWN;
        recycle_mode <= 1'b1;
        simultaneous <= 1'b1;
        transfer_monitored <= 1'b1;
        ext_trigger_in <= 1'b1;
        send(16'h0111, 0, 1);
        send(16'hf922, 1, 1);
        note(16'h0111, 0);
        note(16'h0111, 1);
        note(16'hf922, 0);
        cyc(20);
        go(1);
        ext_trigger_in <= 1'b0;
        wait_updates(3);
        ext_trigger_in <= 1'b1;
        cyc(3);
        ext_trigger_in <= 1'b0;
        wait_updates(2);
        check(data_lost === 1'b0 && sample_ready === 1'b1, "replay");
        go(0);
        go(0);
        $display("test recycle done");
        final_report();
    end
endmodule
bind dac_output_pacing_fifo dac_pacing_props #(.DATA_W(DATA_W), .CHANNELS(CHANNELS)) props_u (
    .core_clk, .rst, .clear_lost, .recycle_mode, .transfer_monitored, .sample_ready,
    .code_format, .range_select_code, .dac_code, .dac_range_10v, .dac_update, .running,
    .data_lost_event, .data_lost);
